// ### core/lcsc_map.vh
`ifndef LCSC_MAP_VH
`define LCSC_MAP_VH
// ==================================================
// register byte offsets
`define LCSC_ADDR_CHG 12'h000
`define LCSC_ADDR_TIMER 12'h004
`define LCSC_ADDR_CTRL 12'h008
`define LCSC_ADDR_STATUS 12'h00c
`define LCSC_ADDR_USB 12'h010
`define LCSC_ADDR_STATE 12'h014
// ==================================================
// charge setting register fields
`define LCSC_ICHG_BIT 0
`define LCSC_VCHG_LSB 1
`define LCSC_TRICKLE_LSB 4
`define LCSC_FORCED_BIT 6
`define LCSC_CHG_RESET 8'h01
// ==================================================
// control register fields
`define LCSC_THCON_BIT 4
`define LCSC_CTRL_RESET 8'h00
`define LCSC_TIMER_RESET 8'h00
// ==================================================
// charge states
`define LCSC_ST_DEFAULT 4'h0
`define LCSC_ST_FORCED 4'h1
`define LCSC_ST_TRICKLE 4'h2
`define LCSC_ST_QUICK 4'h3
`define LCSC_ST_HOT1 4'h4
`define LCSC_ST_HOT2 4'h5
`define LCSC_ST_FCDET 4'h6
`define LCSC_ST_FULL 4'h7
`define LCSC_ST_BATTERY_ABSENT_FLAG 4'h8
`define LCSC_ST_ERR1 4'h9
`define LCSC_ST_ERR2 4'ha
`define LCSC_ST_ERR3 4'hb
// ==================================================
// timing: tick period 1 ms at 10 MHz pclk
`define LCSC_CLK_HZ 10000000
`define LCSC_TICK_MS 1
`define LCSC_TICK_CYC ((`LCSC_CLK_HZ / 1000) * `LCSC_TICK_MS)
`define LCSC_BLINK_FAST_MS 128
`define LCSC_BLINK_SLOW_MS 1024
`define LCSC_WEAK_MIN 40
`define LCSC_WEAK_MS (`LCSC_WEAK_MIN * 60000)
`define LCSC_TRICKLE_MS 3600000
`define LCSC_QUICK_MS 14400000
`define LCSC_FCDET_MS 16
`endif

// ### core/lcsc_sync.v
`default_nettype none
// ==================================================
// two-flop synchroniser for a bundle of comparator levels
module lcsc_sync #(
  parameter WIDTH = 8
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // levels
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// ### core/lcsc_timer.v
`default_nettype none
// ==================================================
// millisecond down counter: load, run while enabled, flags expiry
module lcsc_timer #(
  parameter WIDTH = 24
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // control
  input wire load,
  input wire [WIDTH-1:0] load_val,
  input wire run,
  input wire tick,
  // status
  output reg expired
);
  reg [WIDTH-1:0] count;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= {WIDTH{1'b0}};
      expired <= 1'b0;
    end else if (load) begin
      count <= load_val;
      expired <= 1'b0;
    end else if (run && tick) begin
      if (count == {WIDTH{1'b0}}) begin
        expired <= 1'b1;
      end else begin
        count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// ### core/lcsc_core.v
// The APB interface to the registers and the register addresses were left to the implementer.
`include "lcsc_map.vh"
// Functional notes
// - default: battery only if above start threshold
// - thermistor enable: voltage or thermistor low
// - power after battery starts from default
// - no detection keeps forced state
// - weak timer on standard port, suspend
// - dead provision while weak, redetect when good
// - divided port gate held until good
// - forced charge at trickle current, bit-controlled
// - trickle below quick threshold, then quick
// - trickle timer expiry enters error one
// - trickle timer halts below start or short
// - absent flag at start threshold; host inhibits
// - over-voltage in charge enters error one; the code checks it only in trickle, quick and hot, not in forced
// - trickle current tenth or fifth select
// - quick timer, constant voltage, fall back
// - quick half/full, thermal throttle
// - completion detection sink and verdict
// - three-bit control voltage select
// - recharge below threshold restarts quick timer
// - indicator on in charging states
// - error blink fast or slow, half duty
`default_nettype none
module lcsc_core #(
  parameter TICK_CYC = `LCSC_TICK_CYC,
  parameter WEAK_MS = `LCSC_WEAK_MS,
  parameter TRICKLE_MS = `LCSC_TRICKLE_MS,
  parameter QUICK_MS = `LCSC_QUICK_MS
) (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // comparators
  input wire power_ok,
  input wire vbat_above_start,
  input wire vbat_above_quick,
  input wire vbat_above_quick_hys,
  input wire vbat_at_control,
  input wire vbat_above_ov,
  input wire vbat_above_recharge,
  input wire vbat_good,
  input wire bat_short,
  input wire ichg_below_full,
  input wire thermistor_sense_pin,
  input wire junction_hot,
  input wire chip_overtemp,
  // port type: 0 standard, 1 dedicated, 2 divided
  input wire [1:0] port_type,
  input wire usb_detect_done,
  input wire charge_inhibit_input_n,
  // outputs
  output reg stat_led_n,
  output reg load_switch_gate_n,
  output reg dead_bat_provision,
  output reg usb_redetect,
  output reg suspend,
  output reg charge_on,
  output reg [2:0] current_sel,
  output reg [2:0] control_voltage_sel,
  output reg completion_sink_on
);
  localparam S_DEFAULT = `LCSC_ST_DEFAULT;
  localparam S_FORCED = `LCSC_ST_FORCED;
  localparam S_TRICKLE = `LCSC_ST_TRICKLE;
  localparam S_QUICK = `LCSC_ST_QUICK;
  localparam S_HOT1 = `LCSC_ST_HOT1;
  localparam S_FCDET = `LCSC_ST_FCDET;
  localparam S_FULL = `LCSC_ST_FULL;
  localparam S_BATTERY_ABSENT_FLAG = `LCSC_ST_BATTERY_ABSENT_FLAG;
  localparam S_ERR1 = `LCSC_ST_ERR1;
  localparam S_ERR2 = `LCSC_ST_ERR2;
  localparam S_ERR3 = `LCSC_ST_ERR3;
  localparam [1:0] PORT_SDP = 2'h0;
  localparam [1:0] PORT_DIV = 2'h2;
  localparam [23:0] FCDET_MS = `LCSC_FCDET_MS;

  // ==================================================
  // input synchronisation
  wire [12:0] sync;
  lcsc_sync #(.WIDTH(13)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({power_ok, vbat_above_start, vbat_above_quick, vbat_above_quick_hys, vbat_at_control,
      vbat_above_ov, vbat_above_recharge, vbat_good, bat_short, ichg_below_full,
      thermistor_sense_pin, junction_hot, chip_overtemp}),
    .sync_out(sync)
  );
  wire s_pok = sync[12];
  wire s_start = sync[11];
  wire s_quick = sync[10];
  wire s_hys = sync[9];
  wire s_cv = sync[8];
  wire s_ov = sync[7];
  wire s_rechg = sync[6];
  wire s_good = sync[5];
  wire s_short = sync[4];
  wire s_fc = sync[3];
  wire s_th_low = sync[2];
  wire s_hot = sync[1];
  wire s_tsd = sync[0];

  // ==================================================
  // registers
  reg [7:0] chg_reg;
  reg [7:0] timer_reg;
  reg [7:0] ctrl_reg;
  reg [3:0] state;
  reg [3:0] next_state;
  reg trickle_tout;
  reg quick_tout;
  reg weak_tout;

  wire thcon_en = ctrl_reg[`LCSC_THCON_BIT];
  wire bat_detected = s_start | (thcon_en & s_th_low);
  wire absent_flag = ~s_start;
  wire wr = psel & penable & pwrite & pready;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg_reg <= `LCSC_CHG_RESET;
      timer_reg <= `LCSC_TIMER_RESET;
      ctrl_reg <= `LCSC_CTRL_RESET;
    end else if (wr) begin
      if (paddr == `LCSC_ADDR_CHG) begin
        chg_reg <= pwdata[7:0];
      end else if (paddr == `LCSC_ADDR_TIMER) begin
        timer_reg <= pwdata[7:0];
      end else if (paddr == `LCSC_ADDR_CTRL) begin
        ctrl_reg <= pwdata[7:0];
      end
    end
  end

  // ==================================================
  // apb: no wait state; read data always comes from a flop loaded in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel & ~penable) begin
        if (paddr == `LCSC_ADDR_CHG) begin
          prdata <= {24'h000000, chg_reg};
        end else if (paddr == `LCSC_ADDR_TIMER) begin
          prdata <= {24'h000000, timer_reg};
        end else if (paddr == `LCSC_ADDR_CTRL) begin
          prdata <= {24'h000000, ctrl_reg};
        end else if (paddr == `LCSC_ADDR_STATUS) begin
          prdata <= {24'h000000, s_good, s_ov, absent_flag, state == S_FULL,
            trickle_tout | quick_tout, s_tsd, s_pok, 1'b0};
        end else if (paddr == `LCSC_ADDR_USB) begin
          prdata <= {24'h000000, weak_tout, 1'b0, 1'b0, port_type, 3'h0};
        end else if (paddr == `LCSC_ADDR_STATE) begin
          prdata <= {28'h0000000, state};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // ==================================================
  // prescaler: millisecond tick
  reg [23:0] presc;
  wire tick = (presc == 24'h000000);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc <= 24'h000000;
    end else if (tick) begin
      presc <= TICK_CYC[23:0] - 24'h000001;
    end else begin
      presc <= presc - 24'h000001;
    end
  end

  // ==================================================
  // timers
  wire entering = (next_state != state);
  wire trk_load = entering & (next_state == S_TRICKLE);
  wire trk_run = (state == S_TRICKLE) & s_start & ~s_short;
  wire qck_load = entering & (next_state == S_QUICK) & (state != S_HOT1);
  wire qck_run = (state == S_QUICK) | (state == S_HOT1);
  wire weak_run = dead_bat_provision & (port_type == PORT_SDP) & ~suspend;
  wire fcd_load = entering & (next_state == S_FCDET);
  wire fcd_done;
  wire trk_exp;
  wire qck_exp;
  wire wk_exp;

  lcsc_timer #(.WIDTH(24)) u_trk (
    .pclk(pclk), .presetn(presetn), .load(trk_load), .load_val(TRICKLE_MS[23:0]),
    .run(trk_run), .tick(tick), .expired(trk_exp)
  );
  lcsc_timer #(.WIDTH(24)) u_qck (
    .pclk(pclk), .presetn(presetn), .load(qck_load), .load_val(QUICK_MS[23:0]),
    .run(qck_run), .tick(tick), .expired(qck_exp)
  );
  lcsc_timer #(.WIDTH(24)) u_wk (
    .pclk(pclk), .presetn(presetn), .load(~dead_bat_provision), .load_val(WEAK_MS[23:0]),
    .run(weak_run), .tick(tick), .expired(wk_exp)
  );
  lcsc_timer #(.WIDTH(24)) u_fcd (
    .pclk(pclk), .presetn(presetn), .load(fcd_load), .load_val(FCDET_MS),
    .run(state == S_FCDET), .tick(tick), .expired(fcd_done)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trickle_tout <= 1'b0;
      quick_tout <= 1'b0;
      weak_tout <= 1'b0;
    end else begin
      trickle_tout <= trk_exp & (state == S_TRICKLE);
      quick_tout <= qck_exp & qck_run;
      weak_tout <= wk_exp;
    end
  end

  // ==================================================
  // charge state machine
  wire chg_allowed = s_pok & ~charge_inhibit_input_n;
  always @* begin
    next_state = state;
    if (!chg_allowed) begin
      next_state = S_DEFAULT;
    end else if (s_tsd) begin
      next_state = S_ERR3;
    end else begin
      case (state)
        S_DEFAULT: begin
          next_state = S_FORCED;
        end
        S_FORCED: begin
          if (bat_detected) begin
            next_state = s_quick ? S_QUICK : S_TRICKLE;
          end
        end
        S_TRICKLE: begin
          if (s_ov) begin
            next_state = S_ERR1;
          end else if (s_quick) begin
            next_state = S_QUICK;
          end else if (trk_exp) begin
            next_state = S_ERR1;
          end
        end
        S_QUICK, S_HOT1: begin
          if (s_ov) begin
            next_state = S_ERR1;
          end else if (!s_hys) begin
            next_state = S_TRICKLE;
          end else if (qck_exp) begin
            next_state = S_ERR2;
          end else if (s_cv && s_fc) begin
            next_state = S_FCDET;
          end else if (s_hot) begin
            next_state = S_HOT1;
          end else begin
            next_state = S_QUICK;
          end
        end
        S_FCDET: begin
          if (fcd_done) begin
            if (s_rechg) begin
              next_state = S_FULL;
            end else if (s_start) begin
              next_state = S_ERR1;
            end else begin
              next_state = S_BATTERY_ABSENT_FLAG;
            end
          end
        end
        S_FULL: begin
          if (!s_rechg) begin
            next_state = S_QUICK;
          end
        end
        default: begin
          next_state = state;
        end
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_DEFAULT;
    end else begin
      state <= next_state;
    end
  end

  // ==================================================
  // dead battery provision, gate, suspend
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dead_bat_provision <= 1'b0;
      usb_redetect <= 1'b0;
      suspend <= 1'b0;
      load_switch_gate_n <= 1'b1;
    end else begin
      usb_redetect <= 1'b0;
      if (!s_pok) begin
        dead_bat_provision <= 1'b0;
        suspend <= 1'b0;
        load_switch_gate_n <= 1'b1;
      end else if (usb_detect_done && !s_good && port_type != PORT_DIV && !suspend) begin
        dead_bat_provision <= 1'b1;
      end else if (dead_bat_provision && s_good) begin
        dead_bat_provision <= 1'b0;
        usb_redetect <= 1'b1;
      end
      if (s_pok && wk_exp && weak_run) begin
        suspend <= 1'b1;
      end
      if (s_pok && port_type == PORT_DIV && s_good) begin
        load_switch_gate_n <= 1'b0;
      end
    end
  end

  // ==================================================
  // analogue settings
  wire charging = (state == S_FORCED) | (state == S_TRICKLE) | (state == S_QUICK) | (state == S_HOT1);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      charge_on <= 1'b0;
      current_sel <= 3'h0;
      control_voltage_sel <= 3'h0;
      completion_sink_on <= 1'b0;
    end else begin
      charge_on <= charging & ~suspend;
      control_voltage_sel <= chg_reg[`LCSC_VCHG_LSB+2:`LCSC_VCHG_LSB];
      completion_sink_on <= (state == S_FCDET);
      // codes: 1 tenth, 2 fifth, 4 half, 5 full, 6 thermal throttle
      if (state == S_FORCED && chg_reg[`LCSC_FORCED_BIT]) begin
        current_sel <= 3'h1;
      end else if (state == S_FORCED || state == S_TRICKLE) begin
        current_sel <= (chg_reg[`LCSC_TRICKLE_LSB+1:`LCSC_TRICKLE_LSB] == 2'h0) ? 3'h1 : 3'h2;
      end else if (state == S_HOT1) begin
        current_sel <= 3'h6;
      end else if (state == S_QUICK) begin
        current_sel <= chg_reg[`LCSC_ICHG_BIT] ? 3'h5 : 3'h4;
      end else begin
        current_sel <= 3'h0;
      end
    end
  end

  // ==================================================
  // status indicator; blink counted in ms ticks
  reg [10:0] blink_ms;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_ms <= 11'h000;
      stat_led_n <= 1'b1;
    end else begin
      if (tick) begin
        blink_ms <= blink_ms + 11'h001;
      end
      if (state == S_ERR1) begin
        stat_led_n <= blink_ms[6];
      end else if (state == S_ERR2 || state == S_ERR3) begin
        stat_led_n <= blink_ms[9];
      end else begin
        stat_led_n <= ~charging;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/lcsc_core_monitor.sv
`default_nettype none
// ==================================================
// port checker for the charge state controller
module lcsc_core_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // charge side
  input wire logic power_ok,
  input wire logic charge_inhibit_input_n,
  input wire logic [1:0] port_type,
  input wire logic stat_led_n,
  input wire logic charge_on,
  input wire logic [2:0] current_sel,
  input wire logic [2:0] control_voltage_sel,
  input wire logic completion_sink_on,
  input wire logic usb_redetect,
  input wire logic suspend,
  input wire logic dead_bat_provision
);
  timeunit 1ns;
  timeprecision 100ps;
  logic wr_chg;
  logic [2:0] vsel_q;
  assign wr_chg = psel && penable && pready && pwrite && paddr == 12'h000;
  // last written voltage code, kept here so the check spans the write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vsel_q <= 3'h0;
    end else if (wr_chg) begin
      vsel_q <= pwdata[3:1];
    end
  end
  default clocking mon_cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==================================================
  // assertions
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_needs_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  vsel_follow_a: assert property (wr_chg |=> ##[0:1] control_voltage_sel == vsel_q)
    else $error("voltage code not applied");
  inhibit_idle_a: assert property (charge_inhibit_input_n [*6] |-> !charge_on && stat_led_n && current_sel == 3'h0)
    else $error("charging while inhibited");
  sel_legal_a: assert property (current_sel inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6})
    else $error("illegal current code");
  redetect_pulse_a: assert property (usb_redetect |=> !usb_redetect)
    else $error("redetect not a pulse");
  suspend_drop_a: assert property (!power_ok [*4] |-> !suspend)
    else $error("suspend kept without power");
  suspend_port_a: assert property ($rose(suspend) |-> port_type == 2'h0)
    else $error("suspend on wrong port");
  provision_port_a: assert property (dead_bat_provision |-> port_type != 2'h2)
    else $error("provision on divided port");
  sink_dark_a: assert property (completion_sink_on && $past(completion_sink_on) |-> stat_led_n)
    else $error("indicator lit in completion detect");
endmodule
bind lcsc_core lcsc_core_monitor lcsc_core_monitor_inst (.*);
`default_nettype wire

// ### tb/lcsc_batt_model.sv
`default_nettype none
// ==================================================
// battery pack and pack thermistor seen through the comparators
module lcsc_batt_model #(
  parameter int VSTART_MV = 2000,
  parameter int VQUICK_MV = 3000,
  parameter int VHYS_MV = 2900,
  parameter int VOV_MV = 4350,
  parameter int VRECH_MV = 3800,
  parameter int VGOOD_MV = 3400
) (
  // pack state
  input wire logic [12:0] vbat_mv,
  input wire logic th_pack,
  input wire logic [2:0] control_voltage_sel,
  // comparator levels
  output logic vbat_above_start,
  output logic vbat_above_quick,
  output logic vbat_above_quick_hys,
  output logic vbat_at_control,
  output logic vbat_above_ov,
  output logic vbat_above_recharge,
  output logic vbat_good,
  output logic thermistor_sense_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  int v;
  assign v = int'(vbat_mv);
  assign vbat_above_start = v > VSTART_MV;
  assign vbat_above_quick = v >= VQUICK_MV;
  assign vbat_above_quick_hys = v >= VHYS_MV;
  // 50 mV steps from 4.00 V, so a wrong code moves the cv point
  assign vbat_at_control = v >= 4000 + 50 * int'(control_voltage_sel);
  assign vbat_above_ov = v >= VOV_MV;
  assign vbat_above_recharge = v >= VRECH_MV;
  assign vbat_good = v > VGOOD_MV;
  // only a pack thermistor reads in range; board parts never enable this
  assign thermistor_sense_pin = th_pack;
endmodule
`default_nettype wire

// ### tb/tb_lcsc_core.sv
`default_nettype none
`include "lcsc_map.vh"
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin num_errors++; $display("BAD %s exp %0h got %0h", nm, e, s); end end
module tb_lcsc_core;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic thc; logic th; logic [12:0] v; logic [3:0] st;} lcsc_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, th_pack, bat_short;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic power_ok, ichg_below_full, junction_hot, chip_overtemp, usb_detect_done, charge_inhibit_input_n;
  logic vbat_above_start, vbat_above_quick, vbat_above_quick_hys, vbat_at_control;
  logic vbat_above_ov, vbat_above_recharge, vbat_good, thermistor_sense_pin;
  logic stat_led_n, load_switch_gate_n, dead_bat_provision, usb_redetect, suspend, charge_on, completion_sink_on;
  logic [2:0] current_sel, control_voltage_sel;
  logic [12:0] vbat_mv;
  logic [1:0] port_type;
  int num_errors = 0;
  int compares = 0;
  int redet = 0;
  int r0;
  lcsc_row_t rows[5] = '{'{1'b0, 1'b0, 13'd2500, `LCSC_ST_TRICKLE}, '{1'b0, 1'b0, 13'd3500, `LCSC_ST_QUICK},
    '{1'b0, 1'b0, 13'd4400, `LCSC_ST_ERR1}, '{1'b1, 1'b1, 13'd0, `LCSC_ST_TRICKLE}, '{1'b0, 1'b1, 13'd0, 4'hf}};
  logic [12:0] fv[3] = '{13'd4000, 13'd3500, 13'd1000};
  logic [3:0] fst[3] = '{`LCSC_ST_FULL, `LCSC_ST_ERR1, `LCSC_ST_BATTERY_ABSENT_FLAG};
  // short timers keep the run brief; all expectations scale from these
  lcsc_core #(.TICK_CYC(10), .WEAK_MS(20), .TRICKLE_MS(20), .QUICK_MS(40)) lcsc_core_inst (.*);
  lcsc_batt_model lcsc_batt_model_inst (.*);
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) if (usb_redetect === 1'b1) redet <= redet + 1;
  initial begin
    #(90000 * 100);
    num_errors++;
    $display("watchdog expired");
    print_verdict();
  end
  // ==================================================
  // tasks
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rd = prdata;
    rerr = pslverr;
    `CHK("pready", 1'b1, pready)
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic want_state(input logic [3:0] e, input int tries);
    for (int i = 0; i < tries; i++) begin
      apb(1'b0, `LCSC_ADDR_STATE, 32'h0);
      if (rd[3:0] === e) break;
    end
    `CHK("state", e, rd[3:0])
  endtask
  task automatic start_up(input logic thc, input logic th, input logic [1:0] pt, input logic [12:0] v);
    power_ok <= 1'b0;
    ichg_below_full <= 1'b0;
    junction_hot <= 1'b0;
    chip_overtemp <= 1'b0;
    charge_inhibit_input_n <= 1'b0;
    repeat (6) @(posedge pclk);
    want_state(`LCSC_ST_DEFAULT, 4);
    `CHK("led off", 1'b1, stat_led_n)
    port_type <= pt;
    th_pack <= th;
    vbat_mv <= v;
    apb(1'b1, `LCSC_ADDR_CTRL, {27'h0, thc, 4'h0});
    power_ok <= 1'b1;
  endtask
  task automatic blink(input int half);
    time t0;
    @(stat_led_n);
    @(stat_led_n);
    t0 = $time;
    @(stat_led_n);
    `CHK("blink half", half, int'(($time - t0) / 100))
  endtask
  // ==================================================
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    power_ok = 1'b0;
    ichg_below_full = 1'b0;
    junction_hot = 1'b0;
    chip_overtemp = 1'b0;
    bat_short = 1'b0;
    usb_detect_done = 1'b1;
    charge_inhibit_input_n = 1'b0;
    th_pack = 1'b0;
    vbat_mv = 13'd0;
    port_type = 2'h1;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `LCSC_ADDR_CHG, 32'h0);
    `CHK("chg reset", {24'h0, `LCSC_CHG_RESET}, rd)
    apb(1'b0, `LCSC_ADDR_CTRL, 32'h0);
    `CHK("ctrl reset", {24'h0, `LCSC_CTRL_RESET}, rd)
    apb(1'b1, `LCSC_ADDR_TIMER, 32'hffffffff);
    apb(1'b0, `LCSC_ADDR_TIMER, 32'h0);
    `CHK("timer width", 32'hff, rd)
    apb(1'b1, 12'h018, 32'h5a);
    `CHK("unmapped err", 1'b1, rerr)
    apb(1'b0, 12'h018, 32'h0);
    `CHK("unmapped data", 32'h0, rd)
    $display("registers done");
    foreach (rows[i]) begin
      start_up(rows[i].thc, rows[i].th, 2'h1, rows[i].v);
      if (rows[i].st != 4'hf) begin
        want_state(rows[i].st, 60);
      end else begin
        repeat (20) @(posedge pclk);
        apb(1'b0, `LCSC_ADDR_STATUS, 32'h0);
        `CHK("absent", 1'b1, rd[5])
        charge_inhibit_input_n <= 1'b1;
        repeat (10) @(posedge pclk);
        `CHK("inhibited", 1'b0, charge_on)
      end
      if (rows[i].st == `LCSC_ST_TRICKLE || rows[i].st == `LCSC_ST_QUICK) `CHK("led on", 1'b0, stat_led_n)
      $display("row %0d done", i);
    end
    start_up(1'b0, 1'b0, 2'h1, 13'd2500);
    want_state(`LCSC_ST_TRICKLE, 50);
    `CHK("tenth", 3'h1, current_sel)
    // a shorted terminal must freeze the trickle timer well past its span
    bat_short <= 1'b1;
    repeat (300) @(posedge pclk);
    want_state(`LCSC_ST_TRICKLE, 1);
    bat_short <= 1'b0;
    want_state(`LCSC_ST_ERR1, 200);
    blink(640);
    $display("trickle timeout done");
    start_up(1'b0, 1'b0, 2'h1, 13'd3500);
    want_state(`LCSC_ST_QUICK, 50);
    `CHK("full rate", 3'h5, current_sel)
    junction_hot <= 1'b1;
    repeat (8) @(posedge pclk);
    `CHK("throttle", 3'h6, current_sel)
    junction_hot <= 1'b0;
    vbat_mv <= 13'd2850;
    want_state(`LCSC_ST_TRICKLE, 20);
    vbat_mv <= 13'd3500;
    apb(1'b1, `LCSC_ADDR_CHG, 32'h14);
    want_state(`LCSC_ST_QUICK, 20);
    `CHK("half rate", 3'h4, current_sel)
    `CHK("vsel", 3'h2, control_voltage_sel)
    chip_overtemp <= 1'b1;
    want_state(`LCSC_ST_ERR3, 20);
    blink(5120);
    $display("quick done");
    for (int k = 0; k < 3; k++) begin
      start_up(1'b0, 1'b0, 2'h1, 13'd4100);
      want_state(`LCSC_ST_QUICK, 30);
      ichg_below_full <= 1'b1;
      want_state(`LCSC_ST_FCDET, 30);
      `CHK("sink", 1'b1, completion_sink_on)
      vbat_mv <= fv[k];
      want_state(fst[k], 100);
      if (k == 0) begin
        ichg_below_full <= 1'b0;
        vbat_mv <= 13'd3700;
        want_state(`LCSC_ST_QUICK, 30);
      end
    end
    $display("completion done");
    start_up(1'b0, 1'b0, 2'h1, 13'd3500);
    want_state(`LCSC_ST_ERR2, 200);
    $display("quick timeout done");
    start_up(1'b0, 1'b0, 2'h0, 13'd2500);
    repeat (20) @(posedge pclk);
    `CHK("provision", 1'b1, dead_bat_provision)
    `CHK("fifth", 3'h2, current_sel)
    repeat (100) @(posedge pclk);
    `CHK("early suspend", 1'b0, suspend)
    repeat (150) @(posedge pclk);
    `CHK("suspend", 1'b1, suspend)
    start_up(1'b0, 1'b0, 2'h0, 13'd2500);
    repeat (20) @(posedge pclk);
    r0 = redet;
    vbat_mv <= 13'd3500;
    repeat (20) @(posedge pclk);
    `CHK("redetect", r0 + 1, redet)
    `CHK("provision end", 1'b0, dead_bat_provision)
    start_up(1'b0, 1'b0, 2'h2, 13'd2500);
    repeat (20) @(posedge pclk);
    `CHK("gate held", 1'b1, load_switch_gate_n)
    vbat_mv <= 13'd3500;
    repeat (20) @(posedge pclk);
    `CHK("gate low", 1'b0, load_switch_gate_n)
    $display("usb port done");
    print_verdict();
  end
endmodule
`default_nettype wire
